/* File: src/rgc_pkg.sv */
package rgc_pkg;
  // ---------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_AMP_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_THRESHOLD = 4'h1;
  localparam logic [3:0] ADDR_BANDWIDTH = 4'h2;
  localparam logic [3:0] ADDR_CORR_BW = 4'h3;
  localparam logic [3:0] ADDR_RX_CTRL = 4'h4;
  localparam logic [3:0] ADDR_IPD = 4'h5;
  localparam logic [3:0] ADDR_STRENGTH = 4'h6;
  localparam logic [3:0] ADDR_LIMIT_BASE = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hd;
  localparam logic [3:0] ADDR_REF = 4'he;

  // Field positions
  localparam int ZIN_BIT = 6;
  localparam int NOW_LSB = 3;
  localparam int BW_EXP_LSB = 0;
  localparam int BW_MANT_LSB = 3;
  localparam int CTRL_PKT_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int CTRL_AFC_BIT = 3;
  localparam int CTRL_MOD_LSB = 4;

  // Gain selection codes
  localparam logic [2:0] GAIN_AUTO = 3'h0;
  localparam logic [2:0] GAIN_G1 = 3'h1;
  localparam logic [2:0] GAIN_RSVD = 3'h7;
  localparam int NUM_LIMITS = 5;
  localparam logic [1:0] MOD_FSK = 2'h0;

  // Bandwidth mantissa divisors and exponent offsets
  localparam logic [4:0] MANT_DIV_00 = 5'h10;
  localparam logic [4:0] MANT_DIV_01 = 5'h14;
  localparam logic [4:0] MANT_DIV_10 = 5'h18;
  localparam logic [3:0] EXP_OFS_FSK = 4'h2;
  localparam logic [3:0] EXP_OFS_OOK = 4'h3;

  // Reference terms in whole dB (signed)
  localparam logic signed [9:0] REF_FLOOR_DB = -10'sd174;
  localparam logic signed [9:0] REF_NF_DB = 10'sd7;
  localparam logic signed [9:0] REF_SNR_DB = 10'sd8;
  localparam logic signed [9:0] REF_FADE_DB = 5'sd5;
  localparam logic [1:0] QUALIFY_COUNT = 2'h2;
  localparam int FIR_TAPS = 16;
  localparam int DECIM_LOG2 = 3;

  // Reset values
  localparam logic [7:0] THRESH_RESET = 8'he4;
  localparam logic [7:0] IPD_RESET = 8'h10;

  typedef enum {ST_IDLE, ST_WAIT, ST_CHOOSE, ST_HOLD, ST_DELAY} rgc_state_type;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rgc_req_type;

  typedef struct packed {
    logic strobe;
    logic [7:0] value;
  } rgc_sample_type;
endpackage : rgc_pkg

/* File: src/rgc_top.sv */
`timescale 1ns/10ps
module rgc_top import rgc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Receiver status
  input wire logic rxEnable,
  input wire logic sampleStrobe,
  input wire logic [7:0] signalStrengthValue,
  input wire logic fifoEmpty,
  input wire logic packetDone,
  // Converter bit streams
  input wire logic adcBitI,
  input wire logic adcBitQ,
  // Analog controls and filter outputs
  output logic ampInputImpedanceSel,
  output logic [2:0] ampGainNow,
  output logic [4:0] filterMantissa,
  output logic [3:0] filterShift,
  output logic imageFilterBypass,
  output logic signed [9:0] filtI,
  output logic signed [9:0] filtQ,
  output logic filtValid
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  rgc_req_type req;
  rgc_sample_type smp;
  rgc_state_type state_ff;
  logic zin_ff;
  logic [2:0] gainSel_ff;
  logic [7:0] threshold_ff;
  logic [1:0] mant_ff;
  logic [2:0] exp_ff;
  logic [1:0] afcMant_ff;
  logic [2:0] afcExp_ff;
  logic pktMode_ff;
  logic autoRestart_ff;
  logic afcAuto_ff;
  logic [1:0] modSel_ff;
  logic restartReq_ff;
  logic [7:0] ipd_ff;
  logic [7:0] lastStrength_ff;
  logic [7:0] limit_ff [NUM_LIMITS];
  logic [1:0] qualCnt_ff;
  logic [7:0] delayCnt_ff;
  logic [2:0] autoGain_ff;
  logic afcPhase_ff;
  logic [2:0] nxt_autoGain;
  logic exceeds;
  logic fsk;

  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
  assign smp = '{strobe: sampleStrobe, value: signalStrengthValue};
  assign exceeds = smp.value > threshold_ff;
  assign fsk = modSel_ff == MOD_FSK;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      zin_ff <= 1'b0;
      gainSel_ff <= GAIN_AUTO;
      threshold_ff <= THRESH_RESET;
      mant_ff <= 2'h1;
      exp_ff <= 3'h5;
      afcMant_ff <= 2'h1;
      afcExp_ff <= 3'h3;
      pktMode_ff <= 1'b1;
      autoRestart_ff <= 1'b1;
      afcAuto_ff <= 1'b0;
      modSel_ff <= MOD_FSK;
      ipd_ff <= IPD_RESET;
    end else if (req.wr) begin
      case (req.addr)
        ADDR_AMP_CONFIG: begin
          zin_ff <= req.wdata[ZIN_BIT];
          if (req.wdata[2:0] != GAIN_RSVD) begin
            gainSel_ff <= req.wdata[2:0];
          end
        end
        ADDR_THRESHOLD: threshold_ff <= req.wdata;
        ADDR_BANDWIDTH: begin
          mant_ff <= req.wdata[BW_MANT_LSB +: 2];
          exp_ff <= req.wdata[BW_EXP_LSB +: 3];
        end
        ADDR_CORR_BW: begin
          afcMant_ff <= req.wdata[BW_MANT_LSB +: 2];
          afcExp_ff <= req.wdata[BW_EXP_LSB +: 3];
        end
        ADDR_RX_CTRL: begin
          pktMode_ff <= req.wdata[CTRL_PKT_BIT];
          autoRestart_ff <= req.wdata[CTRL_AUTO_BIT];
          afcAuto_ff <= req.wdata[CTRL_AFC_BIT];
          modSel_ff <= req.wdata[CTRL_MOD_LSB +: 2];
        end
        ADDR_IPD: ipd_ff <= req.wdata;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Power limits for the automatic loop
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LIMITS; gi++) begin : g_lim
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          limit_ff[gi] <= 8'(8'h50 + 8'(gi) * 8'h14);
        end else if (req.wr && req.addr == 4'(ADDR_LIMIT_BASE + 4'(gi))) begin
          limit_ff[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  // Highest-index limit crossed picks the step
  always_comb begin
    nxt_autoGain = GAIN_G1;
    for (int i = 0; i < NUM_LIMITS; i++) begin
      if (smp.value > limit_ff[i]) begin
        nxt_autoGain = 3'(GAIN_G1 + 3'(i) + 3'h1);
      end
    end
  end

  // Restart request: set by write, cleared when wait is entered
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      restartReq_ff <= 1'b0;
    end else if (req.wr && req.addr == ADDR_RX_CTRL &&
                 req.wdata[CTRL_RESTART_BIT]) begin
      restartReq_ff <= 1'b1;
    end else if (state_ff == ST_WAIT || !rxEnable) begin
      restartReq_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Gain sequence
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      qualCnt_ff <= 2'h0;
      delayCnt_ff <= 8'h0;
      autoGain_ff <= GAIN_G1;
      afcPhase_ff <= 1'b0;
    end else if (!rxEnable) begin
      state_ff <= ST_IDLE;
      qualCnt_ff <= 2'h0;
      afcPhase_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_WAIT;
          afcPhase_ff <= afcAuto_ff;
        end
        ST_WAIT: begin
          if (smp.strobe) begin
            if (!exceeds) begin
              qualCnt_ff <= 2'h0;
            end else if (qualCnt_ff == QUALIFY_COUNT - 2'h1) begin
              qualCnt_ff <= 2'h0;
              state_ff <= ST_CHOOSE;
            end else begin
              qualCnt_ff <= 2'(qualCnt_ff + 2'h1);
            end
          end
        end
        ST_CHOOSE: begin
          if (smp.strobe) begin
            autoGain_ff <= nxt_autoGain;
            state_ff <= ST_HOLD;
            afcPhase_ff <= 1'b0;
          end
        end
        ST_HOLD: begin
          if (!pktMode_ff && restartReq_ff) begin
            state_ff <= ST_WAIT;
          end else if (pktMode_ff && autoRestart_ff && packetDone) begin
            state_ff <= ST_DELAY;
          end
          // Packet mode without auto restart keeps the gain
        end
        ST_DELAY: begin
          if (!fifoEmpty) begin
            delayCnt_ff <= 8'h0;
          end else if (delayCnt_ff >= ipd_ff) begin
            delayCnt_ff <= 8'h0;
            state_ff <= ST_WAIT;
          end else begin
            delayCnt_ff <= 8'(delayCnt_ff + 8'h1);
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs to the analog front end
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ampInputImpedanceSel <= 1'b0;
      ampGainNow <= GAIN_G1;
      filterMantissa <= MANT_DIV_01;
      filterShift <= 4'h0;
      imageFilterBypass <= 1'b1;
    end else begin
      logic [1:0] m;
      logic [2:0] e;
      m = afcPhase_ff ? afcMant_ff : mant_ff;
      e = afcPhase_ff ? afcExp_ff : exp_ff;
      ampInputImpedanceSel <= zin_ff;
      ampGainNow <= (gainSel_ff == GAIN_AUTO) ? autoGain_ff
                                               : gainSel_ff;
      case (m)
        2'h0: filterMantissa <= MANT_DIV_00;
        2'h1: filterMantissa <= MANT_DIV_01;
        default: filterMantissa <= MANT_DIV_10;
      endcase
      filterShift <= 4'(4'(e) + (fsk ? EXP_OFS_FSK : EXP_OFS_OOK));
      imageFilterBypass <= fsk;
    end
  end

  // ---------------------------------------------------------------
  // Reference level: 10log10(2*bw) approximated as 3 dB per octave
  // ---------------------------------------------------------------
  logic signed [9:0] refLevel_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      refLevel_ff <= 10'sh0;
    end else begin
      refLevel_ff <= 10'(REF_FLOOR_DB + REF_NF_DB + REF_SNR_DB + REF_FADE_DB
                     + 10'sd66 - 10'sd3 * $signed({6'h0, filterShift})
                     - ((filterMantissa == MANT_DIV_00) ? 10'sd0 :
                        (filterMantissa == MANT_DIV_01) ? 10'sd1 : 10'sd2));
    end
  end

  // ---------------------------------------------------------------
  // Decimation and sixteen-tap FIR per channel
  // ---------------------------------------------------------------
  logic [DECIM_LOG2-1:0] decCnt_ff;
  logic signed [5:0] accI_ff, accQ_ff;
  logic signed [5:0] tapI_ff [FIR_TAPS];
  logic signed [5:0] tapQ_ff [FIR_TAPS];
  logic decDone;
  assign decDone = &decCnt_ff;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      decCnt_ff <= '0;
      accI_ff <= 6'sh0;
      accQ_ff <= 6'sh0;
    end else begin
      decCnt_ff <= DECIM_LOG2'(decCnt_ff + 1'b1);
      accI_ff <= 6'((decDone ? 6'sh0 : accI_ff) + (adcBitI ? 6'sd1 : -6'sd1));
      accQ_ff <= 6'((decDone ? 6'sh0 : accQ_ff) + (adcBitQ ? 6'sd1 : -6'sd1));
    end
  end

  generate
    for (gi = 0; gi < FIR_TAPS; gi++) begin : g_tap
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          tapI_ff[gi] <= 6'sh0;
          tapQ_ff[gi] <= 6'sh0;
        end else if (decDone) begin
          tapI_ff[gi] <= (gi == 0) ? accI_ff : tapI_ff[(gi == 0) ? 0 : gi-1];
          tapQ_ff[gi] <= (gi == 0) ? accQ_ff : tapQ_ff[(gi == 0) ? 0 : gi-1];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      filtI <= 10'sh0;
      filtQ <= 10'sh0;
      filtValid <= 1'b0;
    end else begin
      logic signed [9:0] si;
      logic signed [9:0] sq;
      si = 10'sh0;
      sq = 10'sh0;
      for (int k = 0; k < FIR_TAPS; k++) begin
        si = 10'(si + 10'(tapI_ff[k]));
        sq = 10'(sq + 10'(tapQ_ff[k]));
      end
      filtValid <= decDone;
      if (decDone) begin
        filtI <= si;
        filtQ <= sq;
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      regRdata <= 8'h0;
      lastStrength_ff <= 8'h0;
    end else begin
      if (smp.strobe) begin
        lastStrength_ff <= smp.value;
      end
      regRdata <= 8'h0;
      if (req.rd) begin
        case (req.addr)
          ADDR_AMP_CONFIG: regRdata <= {1'b0, zin_ff, 3'(ampGainNow),
                                        gainSel_ff};
          ADDR_THRESHOLD: regRdata <= threshold_ff;
          ADDR_BANDWIDTH: regRdata <= {3'h0, mant_ff, exp_ff};
          ADDR_CORR_BW: regRdata <= {3'h0, afcMant_ff, afcExp_ff};
          ADDR_RX_CTRL: regRdata <= {2'h0, modSel_ff, afcAuto_ff, 1'b0,
                                     autoRestart_ff, pktMode_ff};
          ADDR_IPD: regRdata <= ipd_ff;
          ADDR_STRENGTH: regRdata <= lastStrength_ff;
          ADDR_STATUS: regRdata <= {4'h0, afcPhase_ff, 3'(state_ff)};
          ADDR_REF: regRdata <= refLevel_ff[7:0];
          default: begin
            if (req.addr >= ADDR_LIMIT_BASE &&
                req.addr < 4'(ADDR_LIMIT_BASE + 4'(NUM_LIMITS))) begin
              regRdata <= limit_ff[3'(req.addr - ADDR_LIMIT_BASE)];
            end
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_hit;
    smp.strobe && exceeds;
  endsequence

  sequence s_second_hit;
    rxEnable && state_ff == ST_WAIT && qualCnt_ff == 2'h1 ##0 s_hit;
  endsequence

  AST_SECOND_HIT: assert property (@(posedge clk) disable iff (!reset_n)
    s_second_hit |=> state_ff == ST_CHOOSE)
    else $error("Second qualifying sample did not end wait");

  AST_WAIT_LEAVES: assert property (@(posedge clk) disable iff (!reset_n)
    state_ff == ST_CHOOSE && $past(state_ff) == ST_WAIT |->
      $past(smp.strobe && exceeds))
    else $error("Wait left without a qualifying sample");
  AST_MISS_CLEARS: assert property (@(posedge clk) disable iff (!reset_n)
    rxEnable && state_ff == ST_WAIT && smp.strobe && !exceeds |=>
      qualCnt_ff == 2'h0)
    else $error("Counter not cleared on low sample");
  AST_RESERVED_KEEP: assert property (@(posedge clk) disable iff (!reset_n)
    req.wr && req.addr == ADDR_AMP_CONFIG && req.wdata[2:0] == GAIN_RSVD
      |=> $stable(gainSel_ff))
    else $error("Reserved gain code accepted");
  AST_MANUAL_GAIN: assert property (@(posedge clk) disable iff (!reset_n)
    gainSel_ff != GAIN_AUTO |=> ampGainNow == $past(gainSel_ff))
    else $error("Manual gain not applied");
  AST_HOLD_GAIN: assert property (@(posedge clk) disable iff (!reset_n)
    state_ff == ST_HOLD && $past(state_ff) == ST_HOLD |-> $stable(autoGain_ff))
    else $error("Gain changed during hold");
  AST_RESTART: assert property (@(posedge clk) disable iff (!reset_n)
    rxEnable && state_ff == ST_HOLD && !pktMode_ff && restartReq_ff |=>
      state_ff == ST_WAIT)
    else $error("Restart not honoured");
  AST_KEEP_PKT: assert property (@(posedge clk) disable iff (!reset_n)
    rxEnable && state_ff == ST_HOLD && pktMode_ff && !autoRestart_ff |=>
      state_ff == ST_HOLD)
    else $error("Gain dropped without auto restart");
  AST_BYPASS: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 imageFilterBypass == ($past(modSel_ff) == MOD_FSK))
    else $error("Image filter bypass wrong");
endmodule : rgc_top

/* File: sim/rgc_rf_source.sv */
`timescale 1ns/10ps
module rgc_rf_source (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Strength samples
  output logic sampleStrobe,
  output logic [7:0] signalStrengthValue,
  // Converter streams
  output logic adcBitI,
  output logic adcBitQ
);
  initial begin
    sampleStrobe = 1'b0;
    signalStrengthValue = 8'h00;
    adcBitI = 1'b0;
    adcBitQ = 1'b0;
  end

  // ---------------------------------------------------------------
  // One-bit converter streams, noisy every clock
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    adcBitI <= 1'($urandom);
    adcBitQ <= 1'($urandom);
  end

  // ---------------------------------------------------------------
  // Strength sample: steady carrier level, as in preamble or a run of ones
  // ---------------------------------------------------------------
  task automatic send(input logic [7:0] v);
    @(posedge clk);
    sampleStrobe <= 1'b1;
    signalStrengthValue <= v;
    @(posedge clk);
    sampleStrobe <= 1'b0;
    // Value is stale outside the strobe
    signalStrengthValue <= ~v;
  endtask : send
endmodule : rgc_rf_source

/* File: sim/rgc_top_tb_top.sv */
`timescale 1ns/10ps
`define CHK(got, want) \
  begin \
    checks++; \
    if ((got) !== (want)) begin \
      miscompares++; \
      $display("MISMATCH %0t ns got %h exp %h", $time, got, want); \
    end \
  end

module rgc_top_tb_top import rgc_pkg::*; ;
  logic clk, reset_n;
  logic [3:0] regAddr;
  logic [7:0] regWdata, regRdata;
  logic regWr, regRd, rxEnable, fifoEmpty, packetDone;
  logic sampleStrobe, adcBitI, adcBitQ;
  logic [7:0] signalStrengthValue;
  logic ampInputImpedanceSel, imageFilterBypass, filtValid;
  logic [2:0] ampGainNow;
  logic [4:0] filterMantissa;
  logic [3:0] filterShift;
  logic signed [9:0] filtI, filtQ;
  int miscompares = 0;
  int checks = 0;
  int limits[$] = '{8'h50, 8'h64, 8'h78, 8'h8c, 8'ha0};
  int bases[6] = '{8'h20, 8'h5a, 8'h6e, 8'h82, 8'h96, 8'hc0};

  rgc_top u_rgc_top (
    .clk(clk), .reset_n(reset_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata),
    .rxEnable(rxEnable), .sampleStrobe(sampleStrobe),
    .signalStrengthValue(signalStrengthValue),
    .fifoEmpty(fifoEmpty), .packetDone(packetDone),
    .adcBitI(adcBitI), .adcBitQ(adcBitQ),
    .ampInputImpedanceSel(ampInputImpedanceSel), .ampGainNow(ampGainNow),
    .filterMantissa(filterMantissa), .filterShift(filterShift),
    .imageFilterBypass(imageFilterBypass),
    .filtI(filtI), .filtQ(filtQ), .filtValid(filtValid)
  );

  rgc_rf_source u_rgc_rf_source (
    .clk(clk), .reset_n(reset_n),
    .sampleStrobe(sampleStrobe),
    .signalStrengthValue(signalStrengthValue),
    .adcBitI(adcBitI), .adcBitQ(adcBitQ)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // Reference model and bus tasks
  // ---------------------------------------------------------------
  function automatic logic [2:0] modelGain(input logic [7:0] p);
    int n = 1;
    foreach (limits[i]) if (p > limits[i]) n++;
    return 3'(n);
  endfunction : modelGain

  task automatic complete_run();
    if (miscompares == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask : rd

  task automatic waitState(input logic [2:0] s);
    logic [7:0] d;
    for (int i = 0; i < 20; i++) begin
      rd(ADDR_STATUS, d);
      if (d[2:0] === s) begin
        checks++;
        return;
      end
    end
    miscompares++;
    $display("MISMATCH %0t ns state wait timed out", $time);
    complete_run();
  endtask : waitState

  // Wait, qualify twice in a row, then choose a gain for power p
  task automatic acquire(input logic [7:0] p);
    logic [7:0] d;
    u_rgc_rf_source.send(8'h70);
    u_rgc_rf_source.send(8'h6f);
    u_rgc_rf_source.send(8'h70);
    rd(ADDR_STATUS, d);
    `CHK(d[2:0], 3'h1);
    u_rgc_rf_source.send(8'h71);
    rd(ADDR_STATUS, d);
    `CHK(d[2:0], 3'h2);
    u_rgc_rf_source.send(p);
    tick(2);
    `CHK(ampGainNow, modelGain(p));
    rd(ADDR_STATUS, d);
    `CHK(d[2:0], 3'h3);
    rd(ADDR_AMP_CONFIG, d);
    `CHK(d[5:3], modelGain(p));
    rd(ADDR_STRENGTH, d);
    `CHK(d, p);
  endtask : acquire

  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d, p;
    int m, e;
    reset_n = 1'b0;
    regAddr = 4'h0;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    rxEnable = 1'b0;
    fifoEmpty = 1'b0;
    packetDone = 1'b0;
    void'($urandom(32'hb08ac135));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tick(1);
    `CHK(ampGainNow, 3'h1);
    `CHK(filterMantissa, 5'h14);
    `CHK(imageFilterBypass, 1'b1);
    rd(ADDR_AMP_CONFIG, d);
    `CHK(d, 8'h08);
    rd(4'h7, d);
    `CHK(d, 8'h00);
    for (int c = 1; c < 7; c++) begin
      wr(ADDR_AMP_CONFIG, 8'(c));
      tick(2);
      `CHK(ampGainNow, 3'(c));
    end
    wr(ADDR_AMP_CONFIG, 8'h47);
    tick(2);
    `CHK(ampGainNow, 3'h6);
    `CHK(ampInputImpedanceSel, 1'b1);
    rd(ADDR_AMP_CONFIG, d);
    `CHK(d[6:0], 7'h76);
    wr(ADDR_AMP_CONFIG, 8'h00);
    tick(2);
    `CHK(ampInputImpedanceSel, 1'b0);
    for (int k = 0; k < 12; k++) begin
      m = $urandom % 3;
      e = $urandom % 8;
      wr(ADDR_RX_CTRL, 8'((k % 2) << CTRL_MOD_LSB));
      wr(ADDR_BANDWIDTH, 8'(m * 8 + e));
      tick(2);
      `CHK(filterMantissa, 5'(16 + 4 * m));
      `CHK(filterShift, 4'(e + 2 + k % 2));
      `CHK(imageFilterBypass, 1'(k % 2 == 0));
    end
    m = 0;
    repeat (80) begin
      @(posedge clk);
      #1;
      if (filtValid === 1'b1) m++;
    end
    `CHK(m, 10);
    wr(ADDR_THRESHOLD, 8'h6f);
    wr(ADDR_RX_CTRL, 8'h00);
    @(posedge clk) rxEnable <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      p = 8'(bases[i] + $urandom % 8);
      acquire(p);
      u_rgc_rf_source.send(8'hff);
      tick(1);
      `CHK(ampGainNow, modelGain(p));
      wr(ADDR_RX_CTRL, 8'h04);
      waitState(3'h1);
    end
    acquire(8'h30);
    wr(ADDR_RX_CTRL, 8'h01);
    @(posedge clk) packetDone <= 1'b1;
    @(posedge clk) packetDone <= 1'b0;
    tick(2);
    `CHK(ampGainNow, 3'h1);
    rd(ADDR_STATUS, d);
    `CHK(d[2:0], 3'h3);
    wr(ADDR_IPD, 8'h06);
    wr(ADDR_RX_CTRL, 8'h03);
    @(posedge clk) packetDone <= 1'b1;
    @(posedge clk) packetDone <= 1'b0;
    tick(2);
    rd(ADDR_STATUS, d);
    `CHK(d[2:0], 3'h4);
    @(posedge clk) fifoEmpty <= 1'b1;
    rd(ADDR_STATUS, d);
    `CHK(d[2:0], 3'h4);
    waitState(3'h1);
    @(posedge clk) rxEnable <= 1'b0;
    wr(ADDR_CORR_BW, 8'h01);
    wr(ADDR_BANDWIDTH, 8'h12);
    wr(ADDR_RX_CTRL, 8'h08);
    @(posedge clk) rxEnable <= 1'b1;
    tick(2);
    `CHK(filterMantissa, 5'h10);
    `CHK(filterShift, 4'h3);
    acquire(8'h9a);
    tick(1);
    `CHK(filterMantissa, 5'h18);
    `CHK(filterShift, 4'h4);
    rd(ADDR_REF, d);
    `CHK(d, 8'(-174 + 7 + 8 + 5 + 66 - 3 * 4 - 2));
    complete_run();
  end
endmodule : rgc_top_tb_top
